// ---- common/ssc_regs.svh ----
// Register offsets, field positions, reset values and fault cause codes
`ifndef SSC_REGS_SVH
`define SSC_REGS_SVH

`define SSC_CTRL_OFF 12'h000
`define SSC_STAT_OFF 12'h004
`define SSC_CNT_OFF 12'h008

`define SSC_CTRL_MSSE 0
`define SSC_CTRL_HSSE 1
`define SSC_CTRL_MXR 2
`define SSC_CTRL_SUM 3
`define SSC_CTRL_RST 4'h0
`define SSC_STAT_SEEN 8
`define SSC_STAT_RST 5'h00
`define SSC_CNT_RST 32'h0000_0000

`define SSC_XWR_SS 3'h2
`define SSC_XWR_RO 3'h1

`define SSC_CAUSE_IF_ACC 5'h01
`define SSC_CAUSE_LD_ACC 5'h05
`define SSC_CAUSE_ST_ACC 5'h07
`define SSC_CAUSE_IF_PG 5'h0c
`define SSC_CAUSE_LD_PG 5'h0d
`define SSC_CAUSE_ST_PG 5'h0f
`define SSC_CAUSE_IF_GPG 5'h14
`define SSC_CAUSE_LD_GPG 5'h15
`define SSC_CAUSE_ST_GPG 5'h17

`endif

// ---- common/ssc_pkg.sv ----
// Types shared by the shadow-stack access checker
package ssc_pkg;
  typedef enum logic [1:0] {PRIV_U = 2'h0, PRIV_S = 2'h1, PRIV_M = 2'h3} ssc_priv_e;
  typedef enum logic [3:0] {
    ACC_LOAD, ACC_STORE, ACC_AMO, ACC_FETCH, ACC_CBO,
    ACC_SS_PUSH, ACC_SS_CPUSH, ACC_SS_POPCHK, ACC_SS_CPOPCHK, ACC_SS_SWAP
  } ssc_acc_e;
  typedef enum logic [1:0] {FK_ACCESS, FK_PAGE, FK_GUEST} ssc_kind_e;
  typedef logic [2:0] ssc_xwr_t;
  typedef logic [4:0] ssc_cause_t;
endpackage : ssc_pkg

// ---- common/ssc_cfg_if.sv ----
// Configuration and fault event carrier between register file and checker
interface ssc_cfg_if;
  logic mSse;
  logic hSse;
  logic make_executable_readable;
  logic sum;
  logic faultEvt;
  ssc_pkg::ssc_cause_t faultCause;
  modport regs (output mSse, output hSse, output make_executable_readable, output sum,
    input faultEvt, input faultCause);
  modport core (input mSse, input hSse, input make_executable_readable, input sum,
    output faultEvt, output faultCause);
endinterface : ssc_cfg_if

// ---- verilog/ssc_pte_decode.sv ----
// Page-table permission decode for one translation stage
module ssc_pte_decode (
  input wire ssc_pkg::ssc_xwr_t xwr,
  input wire logic ssAllowed,
  output logic canRead,
  output logic canWrite,
  output logic canExec,
  output logic ssPage,
  output logic rsvd
);
  import ssc_pkg::*;
  `include "ssc_regs.svh"

  wire logic ssCode = (xwr == `SSC_XWR_SS);
  assign canRead = xwr[0];
  assign canWrite = xwr[1];
  assign canExec = xwr[2];
  assign ssPage = ssCode && ssAllowed;
  assign rsvd = xwr[1] && !xwr[0] && !ssPage;
endmodule : ssc_pte_decode

// ---- verilog/ssc_apb_regs.sv ----
// APB register file: control bits, last fault and fault count
module ssc_apb_regs #(
  parameter int AW = 12
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  ssc_cfg_if.regs cfg
);
  import ssc_pkg::*;
  `include "ssc_regs.svh"

  logic [3:0] ctrl_q;
  ssc_cause_t cause_q;
  logic seen_q;
  logic [31:0] cnt_q;
  logic [31:0] prdata_q;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire logic [11:0] addr = 12'(paddr);
  wire logic hitCtrl = (addr == `SSC_CTRL_OFF);
  wire logic hitStat = (addr == `SSC_STAT_OFF);
  wire logic hitCnt = (addr == `SSC_CNT_OFF);
  wire logic hit = hitCtrl || hitStat || hitCnt;
  wire logic wrEn = psel && penable && pwrite && hit;
  wire logic [31:0] rdMux = hitCtrl ? {28'h000_0000, ctrl_q} :
    hitStat ? {23'h00_0000, seen_q, 3'h0, cause_q} :
    hitCnt ? cnt_q : 32'h0000_0000;
  wire logic seenClr = wrEn && hitStat && pwdata[`SSC_STAT_SEEN];
  wire logic cntClr = wrEn && hitCnt;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = prdata_q;
  assign cfg.mSse = ctrl_q[`SSC_CTRL_MSSE];
  assign cfg.hSse = ctrl_q[`SSC_CTRL_HSSE];
  assign cfg.make_executable_readable = ctrl_q[`SSC_CTRL_MXR];
  assign cfg.sum = ctrl_q[`SSC_CTRL_SUM];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= `SSC_CTRL_RST;
      cause_q <= `SSC_STAT_RST;
      seen_q <= 1'b0;
      cnt_q <= `SSC_CNT_RST;
      prdata_q <= 32'h0000_0000;
    end else begin
      if (wrEn && hitCtrl) ctrl_q <= pwdata[3:0];
      if (cfg.faultEvt) cause_q <= cfg.faultCause;
      seen_q <= cfg.faultEvt || (seen_q && !seenClr);
      cnt_q <= (cntClr ? 32'h0000_0000 : cnt_q) + {31'h0000_0000, cfg.faultEvt};
      if (psel && !penable) prdata_q <= rdMux;
    end
  end
endmodule : ssc_apb_regs

// ---- verilog/ssc_checker.sv ----
// Shadow-stack access permission and fault classification
//
// The register addresses and register access over APB are this design's own decisions.
module ssc_checker #(
  parameter int XLEN = 64,
  parameter int AW = 12
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic accValid,
  input wire ssc_pkg::ssc_acc_e accClass,
  input wire ssc_pkg::ssc_priv_e effPriv,
  input wire logic virtMode,
  input wire logic satpBare,
  input wire logic [2:0] sspLow,
  input wire logic pteValid,
  input wire ssc_pkg::ssc_xwr_t pteXwr,
  input wire logic pteUser,
  input wire logic gStageActive,
  input wire ssc_pkg::ssc_xwr_t gPteXwr,
  input wire logic pmpR,
  input wire logic pmpW,
  input wire logic pmpX,
  input wire logic pmaIdempotent,
  input wire logic pmaAmoSwap,
  output logic respValid,
  output logic faultValid,
  output ssc_pkg::ssc_cause_t faultCause,
  output ssc_pkg::ssc_acc_e respClass
);
  import ssc_pkg::*;
  `include "ssc_regs.svh"

  localparam logic [2:0] ALIGN_MASK = (XLEN == 64) ? 3'h7 : 3'h3;

  ssc_cfg_if cfg ();

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  ssc_apb_regs #(
    .AW(AW)
  ) u_regs (
    .clk(clk),
    .reset_n(reset_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cfg(cfg.regs)
  );

  // ----------------------------------------
  // Access classification
  // ----------------------------------------
  wire logic isSwap = (accClass == ACC_SS_SWAP);
  wire logic isPushPop = (accClass == ACC_SS_PUSH) || (accClass == ACC_SS_CPUSH) ||
    (accClass == ACC_SS_POPCHK) || (accClass == ACC_SS_CPOPCHK);
  wire logic isSs = isPushPop || isSwap;
  wire logic isFetch = (accClass == ACC_FETCH);
  wire logic isLoad = (accClass == ACC_LOAD);
  wire logic privM = (effPriv == PRIV_M);
  wire logic translated = !privM && !satpBare;
  wire logic misalign = isPushPop && ((sspLow & ALIGN_MASK) != 3'h0);
  wire logic ssEn = cfg.mSse && (!virtMode || cfg.hSse);

  // ----------------------------------------
  // Page decode, first and guest stage
  // ----------------------------------------
  logic pR;
  logic pW;
  logic pX;
  logic ssPage;
  logic pteRsvd;
  logic gR;
  logic gW;
  logic gX;
  logic gRsvd;

  ssc_pte_decode u_stage1 (
    .xwr(pteXwr),
    .ssAllowed(ssEn),
    .canRead(pR),
    .canWrite(pW),
    .canExec(pX),
    .ssPage(ssPage),
    .rsvd(pteRsvd)
  );

  ssc_pte_decode u_gstage (
    .xwr(gPteXwr),
    .ssAllowed(1'b0),
    .canRead(gR),
    .canWrite(gW),
    .canExec(gX),
    .ssPage(),
    .rsvd(gRsvd)
  );

  // ----------------------------------------
  // Permission terms
  // ----------------------------------------
  wire logic userOk = pteUser ? ((effPriv == PRIV_U) || (cfg.sum && !isFetch)) :
    (effPriv != PRIV_U);
  wire logic ordOk = isFetch ? pX : isLoad ? (pR || (cfg.make_executable_readable && pX)) : pW;
  wire logic gOk = isSs ? (gR && gW) :
    isFetch ? gX : isLoad ? gR : (gR && gW);
  wire logic pmpOk = isSs ? (pmpR && pmpW) :
    isFetch ? pmpX : isLoad ? pmpR : pmpW;
  wire logic pmaBad = (isSs && !pmaIdempotent) || (isSwap && !pmaAmoSwap);

  // ----------------------------------------
  // Fault priority
  // ----------------------------------------
  logic faultD;
  ssc_kind_e kindD;

  always_comb begin
    faultD = 1'b1;
    kindD = FK_ACCESS;
    if (isSs && privM && isSwap) begin
      kindD = FK_ACCESS;
    end else if (isSs && !privM && (misalign || satpBare)) begin
      kindD = FK_ACCESS;
    end else if (translated && (!pteValid || pteRsvd)) begin
      kindD = FK_PAGE;
    end else if (translated && ssPage && !isSs && !isLoad) begin
      kindD = FK_ACCESS;
    end else if (translated && !userOk) begin
      kindD = FK_PAGE;
    end else if (translated && isSs && (pteXwr == `SSC_XWR_RO)) begin
      kindD = FK_PAGE;
    end else if (translated && isSs && !ssPage) begin
      kindD = FK_ACCESS;
    end else if (translated && !isSs && !ssPage && !ordOk) begin
      kindD = FK_PAGE;
    end else if (gStageActive && (gRsvd || !gOk)) begin
      kindD = FK_GUEST;
    end else if (!pmpOk || pmaBad) begin
      kindD = FK_ACCESS;
    end else begin
      faultD = 1'b0;
    end
  end

  // ----------------------------------------
  // Cause code
  // ----------------------------------------
  function automatic ssc_cause_t causeOf(input ssc_kind_e kind, input logic fetch,
      input logic load);
    ssc_cause_t c;
    c = `SSC_CAUSE_ST_ACC;
    unique case (kind)
      FK_ACCESS: c = fetch ? `SSC_CAUSE_IF_ACC : load ? `SSC_CAUSE_LD_ACC : `SSC_CAUSE_ST_ACC;
      FK_PAGE: c = fetch ? `SSC_CAUSE_IF_PG : load ? `SSC_CAUSE_LD_PG : `SSC_CAUSE_ST_PG;
      FK_GUEST: c = fetch ? `SSC_CAUSE_IF_GPG : load ? `SSC_CAUSE_LD_GPG : `SSC_CAUSE_ST_GPG;
      default: c = `SSC_CAUSE_ST_ACC;
    endcase
    return c;
  endfunction : causeOf

  // Shadow instructions always report as store type
  wire ssc_cause_t causeD = causeOf(kindD, isFetch && !isSs, isLoad && !isSs);
  wire logic faultEvtD = accValid && faultD;

  assign cfg.faultEvt = faultEvtD;
  assign cfg.faultCause = causeD;

  // ----------------------------------------
  // Result registers
  // ----------------------------------------
  logic respValid_q;
  logic faultValid_q;
  ssc_cause_t faultCause_q;
  ssc_acc_e respClass_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      respValid_q <= 1'b0;
      faultValid_q <= 1'b0;
      faultCause_q <= 5'h00;
      respClass_q <= ACC_LOAD;
    end else begin
      respValid_q <= accValid;
      faultValid_q <= faultEvtD;
      faultCause_q <= faultEvtD ? causeD : 5'h00;
      respClass_q <= accClass;
    end
  end

  assign respValid = respValid_q;
  assign faultValid = faultValid_q;
  assign faultCause = faultCause_q;
  assign respClass = respClass_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  ss_page_load_a: assert property (
    accValid && isLoad && translated && pteValid && pteXwr == `SSC_XWR_SS && !ssEn
    |=> faultValid && faultCause == `SSC_CAUSE_LD_PG)
    else $error("disabled shadow encoding not reserved");

  bare_ss_fault_a: assert property (
    accValid && isSs && !privM && satpBare
    |=> faultValid && faultCause == `SSC_CAUSE_ST_ACC)
    else $error("bare shadow access not refused");

  mmode_swap_a: assert property (
    accValid && isSwap && privM |=> faultValid && faultCause == `SSC_CAUSE_ST_ACC)
    else $error("machine swap not refused");

  ss_write_a: assert property (
    accValid && translated && pteValid && ssPage &&
    (accClass == ACC_STORE || accClass == ACC_AMO)
    |=> faultValid && faultCause == `SSC_CAUSE_ST_ACC)
    else $error("store to shadow page not access fault");

  ss_cbo_a: assert property (
    accValid && accClass == ACC_CBO && translated && pteValid && ssPage
    |=> faultValid && faultCause == `SSC_CAUSE_ST_ACC)
    else $error("cache op on shadow page allowed");

  ss_fetch_a: assert property (
    accValid && isFetch && translated && pteValid && ssPage
    |=> faultValid && faultCause == `SSC_CAUSE_IF_ACC)
    else $error("fetch from shadow page allowed");

  ss_read_ok_a: assert property (
    accValid && isLoad && translated && pteValid && ssPage && userOk &&
    !gStageActive && pmpR |=> !faultValid)
    else $error("load from shadow page refused");

  ss_cause_set_a: assert property (
    accValid && isSs |=> !faultValid || faultCause inside
    {`SSC_CAUSE_ST_ACC, `SSC_CAUSE_ST_PG, `SSC_CAUSE_ST_GPG})
    else $error("shadow fault with non-store cause");

  ss_readonly_a: assert property (
    accValid && isSs && translated && !misalign && pteValid && userOk &&
    pteXwr == `SSC_XWR_RO |=> faultValid && faultCause == `SSC_CAUSE_ST_PG)
    else $error("read-only page not page fault");

  ss_other_page_a: assert property (
    accValid && isSs && translated && !misalign && pteValid && !pteRsvd && userOk &&
    !ssPage && pteXwr != `SSC_XWR_RO |=> faultValid && faultCause == `SSC_CAUSE_ST_ACC)
    else $error("shadow access to wrong page type allowed");

  ss_misalign_a: assert property (
    accValid && isPushPop && !privM && misalign
    |=> faultValid && faultCause == `SSC_CAUSE_ST_ACC)
    else $error("misaligned shadow access not refused");

  ss_pma_pmp_a: assert property (
    accValid && isSs && (!pmaIdempotent || !(pmpR && pmpW) || (isSwap && !pmaAmoSwap))
    |=> faultValid)
    else $error("shadow access passed bad memory checks");

  ss_guest_a: assert property (
    accValid && isSs && translated && !misalign && pteValid && userOk && ssPage &&
    gStageActive && !(gR && gW) |=> faultValid && faultCause == `SSC_CAUSE_ST_GPG)
    else $error("guest stage read-write not enforced");

  resp_track_a: assert property (
    accValid |=> respValid && respClass == $past(accClass) &&
    (faultValid == (faultCause != 5'h00)))
    else $error("response not aligned with access");
endmodule : ssc_checker

// ---- testbench/ssc_pipe_model.sv ----
// Pipeline and walker model that presents one access per request
module ssc_pipe_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic go,
  input wire logic [24:0] req,
  output logic accValid,
  output logic [24:0] acc
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [24:0] last_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      last_q <= 25'h000_0000;
    end else if (go) begin
      last_q <= req;
    end
  end
  // One access per cycle; idle fields show the inverse of the last access
  assign accValid = go;
  assign acc = go ? req : ~last_q;
endmodule : ssc_pipe_model

// ---- testbench/tb.sv ----
// Self-checking bench for the shadow-stack access checker
`include "ssc_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ssc_pkg::*;
  localparam ssc_cause_t SA = `SSC_CAUSE_ST_ACC;
  localparam ssc_cause_t SP = `SSC_CAUSE_ST_PG;
  localparam ssc_cause_t SG = `SSC_CAUSE_ST_GPG;
  localparam ssc_cause_t LP = `SSC_CAUSE_LD_PG;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, accValid, respValid, faultValid, go = 1'b0;
  logic [24:0] req = 25'h000_0000;
  logic [24:0] pv;
  ssc_cause_t faultCause;
  ssc_acc_e respClass;
  logic virt, bare, pteV, user, gact, idem, swap;
  logic [2:0] ssp, gxwr, phys_protection_check;
  int errCount = 0, totalChecks = 0, nFault = 0;
  ssc_cause_t lastCause = 5'h00;
  ssc_xwr_t bad [4] = '{3'h3, 3'h7, 3'h5, 3'h4};
  // ----------------------------------------
  // Clock, model and design
  // ----------------------------------------
  initial begin
    forever #50 clk = ~clk;
  end
  ssc_pipe_model u_model (.clk(clk), .reset_n(reset_n), .go(go), .req(req),
    .accValid(accValid), .acc(pv));
  ssc_checker #(.XLEN(64), .AW(12)) u_dut (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .accValid(accValid),
    .accClass(ssc_acc_e'(pv[24:21])), .effPriv(ssc_priv_e'(pv[20:19])), .virtMode(pv[18]),
    .satpBare(pv[17]), .sspLow(pv[16:14]), .pteValid(pv[13]), .pteXwr(pv[12:10]),
    .pteUser(pv[9]), .gStageActive(pv[8]), .gPteXwr(pv[7:5]), .pmpR(pv[4]), .pmpW(pv[3]),
    .pmpX(pv[2]), .pmaIdempotent(pv[1]), .pmaAmoSwap(pv[0]), .respValid(respValid),
    .faultValid(faultValid), .faultCause(faultCause), .respClass(respClass));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tallyAndFinish();
    $display("checks %0d errors %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tallyAndFinish
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] ed, input logic ee);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 100) begin
      errCount++;
      tallyAndFinish();
    end
    if (!w) chk("prdata", prdata, ed);
    chk("pslverr", 32'(pslverr), 32'(ee));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic dflt();
    virt = 1'b0;
    bare = 1'b0;
    ssp = 3'h0;
    pteV = 1'b1;
    user = 1'b0;
    gact = 1'b0;
    gxwr = 3'h3;
    phys_protection_check = 3'h7;
    idem = 1'b1;
    swap = 1'b1;
  endtask : dflt
  task automatic acc(input ssc_acc_e c, input ssc_priv_e p, input ssc_xwr_t x,
      input ssc_cause_t ec);
    @(posedge clk);
    go <= 1'b1;
    req <= {c, p, virt, bare, ssp, pteV, x, user, gact, gxwr, phys_protection_check, idem, swap};
    @(posedge clk);
    go <= 1'b0;
    @(negedge clk);
    chk("respValid", 32'(respValid), 32'h0000_0001);
    chk("faultValid", 32'(faultValid), 32'(ec != 5'h00));
    chk("faultCause", 32'(faultCause), 32'(ec));
    chk("respClass", 32'(respClass), 32'(c));
    if (ec != 5'h00) nFault++;
    lastCause = ec;
    dflt();
  endtask : acc
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    dflt();
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    xfer(1'b0, `SSC_CTRL_OFF, 32'h0000_0000, 32'h0000_0000, 1'b0);
    xfer(1'b0, `SSC_STAT_OFF, 32'h0000_0000, 32'h0000_0000, 1'b0);
    xfer(1'b0, `SSC_CNT_OFF, 32'h0000_0000, 32'h0000_0000, 1'b0);
    xfer(1'b0, 12'h00C, 32'h0000_0000, 32'h0000_0000, 1'b1);
    xfer(1'b1, 12'h00C, 32'h0000_FFFF, 32'h0000_0000, 1'b1);
    acc(ACC_SS_PUSH, PRIV_S, 3'h2, SP);
    acc(ACC_LOAD, PRIV_S, 3'h2, LP);
    xfer(1'b1, `SSC_CTRL_OFF, 32'h0000_0001, 32'h0000_0000, 1'b0);
    virt = 1'b1;
    acc(ACC_SS_PUSH, PRIV_S, 3'h2, SP);
    acc(ACC_SS_PUSH, PRIV_S, 3'h2, 5'h00);
    xfer(1'b1, `SSC_CTRL_OFF, 32'h0000_0003, 32'h0000_0000, 1'b0);
    xfer(1'b0, `SSC_CTRL_OFF, 32'h0000_0000, 32'h0000_0003, 1'b0);
    virt = 1'b1;
    user = 1'b1;
    acc(ACC_SS_CPUSH, PRIV_U, 3'h2, 5'h00);
    acc(ACC_SS_PUSH, PRIV_S, 3'h1, SP);
    acc(ACC_SS_POPCHK, PRIV_S, 3'h1, SP);
    for (int i = 0; i < 4; i++) acc(ACC_SS_PUSH, PRIV_S, bad[i], SA);
    acc(ACC_STORE, PRIV_S, 3'h2, SA);
    acc(ACC_AMO, PRIV_S, 3'h2, SA);
    acc(ACC_STORE, PRIV_S, 3'h3, 5'h00);
    acc(ACC_CBO, PRIV_S, 3'h2, SA);
    acc(ACC_FETCH, PRIV_S, 3'h2, `SSC_CAUSE_IF_ACC);
    acc(ACC_LOAD, PRIV_S, 3'h2, 5'h00);
    pteV = 1'b0;
    acc(ACC_LOAD, PRIV_S, 3'h3, LP);
    xfer(1'b1, `SSC_CTRL_OFF, 32'h0000_0007, 32'h0000_0000, 1'b0);
    acc(ACC_LOAD, PRIV_S, 3'h2, 5'h00);
    bare = 1'b1;
    acc(ACC_SS_POPCHK, PRIV_U, 3'h2, SA);
    bare = 1'b1;
    acc(ACC_SS_PUSH, PRIV_S, 3'h2, SA);
    acc(ACC_SS_SWAP, PRIV_M, 3'h2, SA);
    ssp = 3'h4;
    acc(ACC_SS_PUSH, PRIV_S, 3'h2, SA);
    ssp = 3'h4;
    acc(ACC_SS_CPOPCHK, PRIV_S, 3'h2, SA);
    idem = 1'b0;
    acc(ACC_SS_POPCHK, PRIV_S, 3'h2, SA);
    phys_protection_check = 3'h5;
    acc(ACC_SS_PUSH, PRIV_S, 3'h2, SA);
    phys_protection_check = 3'h3;
    acc(ACC_SS_POPCHK, PRIV_S, 3'h2, SA);
    swap = 1'b0;
    acc(ACC_SS_SWAP, PRIV_S, 3'h2, SA);
    acc(ACC_SS_SWAP, PRIV_S, 3'h2, 5'h00);
    acc(ACC_SS_PUSH, PRIV_U, 3'h2, SP);
    user = 1'b1;
    acc(ACC_SS_PUSH, PRIV_U, 3'h2, 5'h00);
    user = 1'b1;
    acc(ACC_SS_PUSH, PRIV_S, 3'h2, SP);
    xfer(1'b1, `SSC_CTRL_OFF, 32'h0000_000B, 32'h0000_0000, 1'b0);
    user = 1'b1;
    acc(ACC_SS_PUSH, PRIV_S, 3'h2, 5'h00);
    gact = 1'b1;
    acc(ACC_SS_PUSH, PRIV_S, 3'h2, 5'h00);
    gact = 1'b1;
    gxwr = 3'h2;
    acc(ACC_SS_POPCHK, PRIV_S, 3'h2, SG);
    gact = 1'b1;
    gxwr = 3'h1;
    acc(ACC_SS_PUSH, PRIV_S, 3'h2, SG);
    xfer(1'b0, `SSC_STAT_OFF, 32'h0000_0000, 32'h0000_0100 | 32'(lastCause), 1'b0);
    xfer(1'b0, `SSC_CNT_OFF, 32'h0000_0000, 32'(nFault), 1'b0);
    xfer(1'b1, `SSC_STAT_OFF, 32'h0000_0100, 32'h0000_0000, 1'b0);
    xfer(1'b0, `SSC_STAT_OFF, 32'h0000_0000, 32'(lastCause), 1'b0);
    xfer(1'b1, `SSC_CNT_OFF, 32'h0000_0000, 32'h0000_0000, 1'b0);
    xfer(1'b0, `SSC_CNT_OFF, 32'h0000_0000, 32'h0000_0000, 1'b0);
    tallyAndFinish();
  end
  initial begin
    repeat (20000) @(posedge clk);
    errCount++;
    tallyAndFinish();
  end
endmodule : tb
